/* dma_pkg.sv */
// Shared constants and types of the DMA channel controller.
package dma_pkg;
   localparam int unsigned NUM_CH   = 4;
   localparam int unsigned NUM_TRIG = 16;

   // Register byte offsets.
   localparam logic [7:0] OFF_CON     = 8'h00;
   localparam logic [7:0] OFF_UPPER   = 8'h04;
   localparam logic [7:0] OFF_LOWER   = 8'h08;
   localparam logic [7:0] OFF_STATUS  = 8'h0C;
   localparam logic [7:0] OFF_MASK    = 8'h10;
   localparam logic [7:0] OFF_GATE    = 8'h14;
   localparam logic [1:0] CH_BLOCK    = 2'h1;
   localparam logic [1:0] CH_CTRL     = 2'h0;
   localparam logic [1:0] CH_SRC      = 2'h1;
   localparam logic [1:0] CH_DST      = 2'h2;
   localparam logic [1:0] CH_CNT      = 2'h3;

   // Field positions.
   localparam int unsigned CON_ON_BIT     = 15;
   localparam int unsigned CON_SCHEME_BIT = 0;
   localparam int unsigned CTRL_ON_BIT    = 0;
   localparam int unsigned CTRL_BYTE_BIT  = 1;
   localparam int unsigned CTRL_KIND_LSB  = 2;
   localparam int unsigned CTRL_SRCK_LSB  = 4;
   localparam int unsigned CTRL_DSTK_LSB  = 6;
   localparam int unsigned CTRL_TSEL_LSB  = 8;
   localparam int unsigned ST_DONE_LSB    = 0;
   localparam int unsigned ST_OVRUN_LSB   = 4;
   localparam int unsigned ST_BOUND_LSB   = 8;

   // Values after reset.
   localparam logic [15:0] CNT_RESET  = 16'h0001;
   localparam logic [15:0] ADDR_RESET = 16'h0000;
   localparam logic [15:0] CNT_ZERO   = 16'h0000;

   // Transfer kinds.
   localparam logic [1:0] KIND_ONE_SHOT   = 2'h0;
   localparam logic [1:0] KIND_REP_ONE    = 2'h1;
   localparam logic [1:0] KIND_CONTINUOUS = 2'h2;
   localparam logic [1:0] KIND_REP_CONT   = 2'h3;

   // Address kinds; peripheral_indirect uses the pointer as a fixed base.
   localparam logic [1:0] ADDR_FIXED  = 2'h0;
   localparam logic [1:0] ADDR_INC    = 2'h1;
   localparam logic [1:0] ADDR_DEC    = 2'h2;
   localparam logic [1:0] ADDR_PERIPH = 2'h3;

   localparam logic [15:0] STEP_BYTE = 16'h0001;
   localparam logic [15:0] STEP_WORD = 16'h0002;

   typedef enum logic [1:0] {ENG_IDLE, ENG_READ, ENG_WRITE} eng_state_t;
endpackage : dma_pkg

/* arb_if.sv */
// Arbitration signals between the channel engine and the arbiter.
`timescale 1ns/1ps
interface arb_if;
   logic [3:0] request;
   logic       scheme;
   logic       advance;
   logic [1:0] winner;
   logic       found;
   modport arbiter (input request, input scheme, input advance, output winner, output found);
   modport engine  (output request, output scheme, output advance, input winner, input found);
endinterface : arb_if

/* channel_arbiter.sv */
// Fixed or round-robin choice among the requesting channels.
`timescale 1ns/1ps
module channel_arbiter (
   input  wire logic  clk_sys,
   input  wire logic  reset,
   arb_if.arbiter     arb
);
   typedef struct packed {
      logic [1:0] start;
   } arb_state_t;

   arb_state_t s_q;
   arb_state_t s_d;
   logic [2:0] pick_r;

   // Returns found flag and index of the first request at or after start.
   function automatic logic [2:0] pick(input logic [3:0] req, input logic [1:0] start);
      logic [2:0] r;
      logic [1:0] idx;
      r = 3'h0;
      for (int i = 3; i >= 0; i--)
      begin
         idx = 2'(start + 2'(i));
         if (req[idx])
            r = {1'b1, idx};
      end
      return r;
   endfunction : pick

   always_comb
   begin
      s_d = s_q;
      // Fixed scheme always starts at channel 0, so the lowest wins.
      pick_r = pick(arb.request, arb.scheme ? s_q.start : 2'h0);
      if (arb.advance)
         s_d.start = 2'(pick_r[1:0] + 2'h1);
      arb.found  = pick_r[2];
      arb.winner = pick_r[1:0];
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
         s_q <= '0;
      else
         s_q <= s_d;
   end
endmodule : channel_arbiter

/* dma_channels.sv */
// Four-channel DMA engine with APB registers, triggers and low-power abort.
`timescale 1ns/1ps
module dma_channels (
   input  wire logic        clk_sys,
   input  wire logic        reset,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [15:0] trig_in,
   input  wire logic        idle_mode,
   input  wire logic        sleep_mode,
   output logic             mem_req,
   output logic             mem_we,
   output logic             mem_byte,
   output logic      [15:0] mem_addr,
   output logic      [15:0] mem_wdata,
   input  wire logic [15:0] mem_rdata,
   input  wire logic        mem_ack,
   output logic      [3:0]  chan_event,
   output logic             irq
);
   typedef struct packed {
      logic [15:0]       trig_s1;
      logic [15:0]       trig_s2;
      logic [15:0]       trig_s3;
      logic              idle_s1;
      logic              idle_s2;
      logic              sleep_s1;
      logic              sleep_s2;
      logic              ctl_on;
      logic              scheme;
      logic [15:0]       upper;
      logic [15:0]       lower;
      logic [11:0]       status;
      logic [11:0]       mask;
      logic              gate;
      logic [3:0]        chan_on;
      logic [3:0]        byte_size;
      logic [3:0]        pending;
      logic [3:0]        evt;
      logic [3:0][1:0]   kind;
      logic [3:0][1:0]   src_kind;
      logic [3:0][1:0]   dst_kind;
      logic [3:0][4:0]   trig_sel;
      logic [3:0][15:0]  src;
      logic [3:0][15:0]  dst;
      logic [3:0][15:0]  cnt;
      logic [3:0][15:0]  src_init;
      logic [3:0][15:0]  dst_init;
      logic [3:0][15:0]  cnt_init;
      dma_pkg::eng_state_t state;
      logic [1:0]        cur;
      logic [15:0]       addr;
      logic [15:0]       wdata;
      logic              we;
      logic [31:0]       prdata;
      logic              pslverr;
   } dma_state_t;

   dma_state_t  s_q;
   dma_state_t  s_d;
   logic        lp;
   logic [3:0]  allow;
   logic [3:0]  fire;
   logic [11:0] set_v;
   logic [15:0] t_edge;
   logic [15:0] cnt_next;
   logic [1:0]  c;
   logic [32:0] rd;

   arb_if arb ();

   channel_arbiter u_arb (
      .clk_sys (clk_sys),
      .reset   (reset),
      .arb     (arb)
   );

   // Next pointer value after one element for the given address kind.
   function automatic logic [15:0] step(input logic [15:0] a, input logic [1:0] k,
                                        input logic b);
      logic [15:0] d;
      d = b ? dma_pkg::STEP_BYTE : dma_pkg::STEP_WORD;
      case (k)
         dma_pkg::ADDR_INC: return 16'(a + d);
         dma_pkg::ADDR_DEC: return 16'(a - d);
         default:           return a;
      endcase
   endfunction : step

   // Address window check; a zero upper bound leaves the window open.
   function automatic logic outside(input logic [15:0] a, input dma_state_t s);
      return (s.upper != dma_pkg::ADDR_RESET) && ((a > s.upper) || (a < s.lower));
   endfunction : outside

   // Read decode: bit 32 flags an unmapped address.
   function automatic logic [32:0] read_word(input dma_state_t s, input logic [7:0] a);
      logic [1:0]  ch;
      logic [31:0] v;
      logic        miss;
      ch   = a[5:4];
      v    = 32'h0000_0000;
      miss = 1'b0;
      if (a[1:0] != 2'h0)
         miss = 1'b1;
      else if (a[7:6] == dma_pkg::CH_BLOCK)
      begin
         // A gated channel group reads as zero.
         if (!s.gate)
         begin
            case (a[3:2])
               dma_pkg::CH_CTRL: v = 32'({s.trig_sel[ch], s.dst_kind[ch], s.src_kind[ch],
                                          s.kind[ch], s.byte_size[ch], s.chan_on[ch]});
               dma_pkg::CH_SRC:  v = 32'(s.src[ch]);
               dma_pkg::CH_DST:  v = 32'(s.dst[ch]);
               default:          v = 32'(s.cnt[ch]);
            endcase
         end
      end
      else
      begin
         case (a)
            dma_pkg::OFF_CON:    v = 32'({s.ctl_on, 14'h0000, s.scheme});
            dma_pkg::OFF_UPPER:  v = 32'(s.upper);
            dma_pkg::OFF_LOWER:  v = 32'(s.lower);
            dma_pkg::OFF_STATUS: v = 32'(s.status);
            dma_pkg::OFF_MASK:   v = 32'(s.mask);
            dma_pkg::OFF_GATE:   v = 32'(s.gate);
            default:             miss = 1'b1;
         endcase
      end
      return {miss, v};
   endfunction : read_word

   always_comb
   begin
      s_d      = s_q;
      set_v    = 12'h000;
      fire     = 4'h0;
      cnt_next = 16'(s_q.cnt[s_q.cur] - 16'h0001);
      c        = paddr[5:4];
      rd       = read_word(s_q, paddr);
      s_d.evt  = 4'h0;
      s_d.trig_s1  = trig_in;
      s_d.trig_s2  = s_q.trig_s1;
      s_d.trig_s3  = s_q.trig_s2;
      s_d.idle_s1  = idle_mode;
      s_d.idle_s2  = s_q.idle_s1;
      s_d.sleep_s1 = sleep_mode;
      s_d.sleep_s2 = s_q.sleep_s1;
      t_edge = s_q.trig_s2 & ~s_q.trig_s3;
      lp     = s_q.idle_s2 | s_q.sleep_s2;
      for (int i = 0; i < 4; i++)
         allow[i] = s_q.ctl_on & s_q.chan_on[i] & ~s_q.gate & ~lp;

      // APB: read data and error are prepared in the setup cycle.
      if (psel && !penable)
      begin
         s_d.prdata  = rd[31:0];
         s_d.pslverr = rd[32];
      end
      if (psel && penable && pwrite && !s_q.pslverr)
      begin
         if (paddr[7:6] == dma_pkg::CH_BLOCK)
         begin
            if (!s_q.gate)
            begin
               case (paddr[3:2])
                  dma_pkg::CH_CTRL:
                  begin
                     s_d.chan_on[c]   = pwdata[dma_pkg::CTRL_ON_BIT];
                     s_d.byte_size[c] = pwdata[dma_pkg::CTRL_BYTE_BIT];
                     s_d.kind[c]      = pwdata[dma_pkg::CTRL_KIND_LSB +: 2];
                     s_d.src_kind[c]  = pwdata[dma_pkg::CTRL_SRCK_LSB +: 2];
                     s_d.dst_kind[c]  = pwdata[dma_pkg::CTRL_DSTK_LSB +: 2];
                     s_d.trig_sel[c]  = pwdata[dma_pkg::CTRL_TSEL_LSB +: 5];
                  end
                  dma_pkg::CH_SRC:
                  begin
                     s_d.src[c]      = pwdata[15:0];
                     s_d.src_init[c] = pwdata[15:0];
                  end
                  dma_pkg::CH_DST:
                  begin
                     s_d.dst[c]      = pwdata[15:0];
                     s_d.dst_init[c] = pwdata[15:0];
                  end
                  default:
                  begin
                     s_d.cnt[c]      = pwdata[15:0];
                     s_d.cnt_init[c] = pwdata[15:0];
                  end
               endcase
            end
         end
         else
         begin
            case (paddr)
               dma_pkg::OFF_CON:
               begin
                  s_d.ctl_on = pwdata[dma_pkg::CON_ON_BIT];
                  s_d.scheme = pwdata[dma_pkg::CON_SCHEME_BIT];
               end
               dma_pkg::OFF_UPPER:  s_d.upper  = pwdata[15:0];
               dma_pkg::OFF_LOWER:  s_d.lower  = pwdata[15:0];
               dma_pkg::OFF_STATUS: s_d.status = s_q.status & ~pwdata[11:0];
               dma_pkg::OFF_MASK:   s_d.mask   = pwdata[11:0];
               default:             s_d.gate   = pwdata[0];
            endcase
         end
      end

      // Transfer engine.
      arb.request = s_q.pending & allow;
      arb.scheme  = s_q.scheme;
      arb.advance = 1'b0;
      case (s_q.state)
         dma_pkg::ENG_IDLE:
         begin
            if (arb.found)
            begin
               s_d.cur   = arb.winner;
               s_d.addr  = s_q.src[arb.winner];
               s_d.we    = 1'b0;
               s_d.state = dma_pkg::ENG_READ;
            end
         end
         dma_pkg::ENG_READ, dma_pkg::ENG_WRITE:
         begin
            if (!allow[s_q.cur])
               s_d.state = dma_pkg::ENG_IDLE;
            else if (outside(s_q.addr, s_q))
            begin
               set_v[dma_pkg::ST_BOUND_LSB + 32'(s_q.cur)] = 1'b1;
               s_d.chan_on[s_q.cur] = 1'b0;
               s_d.pending[s_q.cur] = 1'b0;
               s_d.state = dma_pkg::ENG_IDLE;
            end
            else if (mem_ack && s_q.state == dma_pkg::ENG_READ)
            begin
               s_d.wdata = s_q.byte_size[s_q.cur] ? {8'h00, mem_rdata[7:0]} : mem_rdata;
               s_d.addr  = s_q.dst[s_q.cur];
               s_d.we    = 1'b1;
               s_d.state = dma_pkg::ENG_WRITE;
            end
            else if (mem_ack)
            begin
               // One element moved; pointers advance afterwards.
               s_d.src[s_q.cur] = step(s_q.src[s_q.cur], s_q.src_kind[s_q.cur],
                                       s_q.byte_size[s_q.cur]);
               s_d.dst[s_q.cur] = step(s_q.dst[s_q.cur], s_q.dst_kind[s_q.cur],
                                       s_q.byte_size[s_q.cur]);
               s_d.cnt[s_q.cur] = cnt_next;
               s_d.we    = 1'b0;
               s_d.state = dma_pkg::ENG_IDLE;
               arb.advance = 1'b1;
               if (s_q.kind[s_q.cur] == dma_pkg::KIND_ONE_SHOT ||
                   s_q.kind[s_q.cur] == dma_pkg::KIND_REP_ONE)
                  s_d.pending[s_q.cur] = 1'b0;
               if (cnt_next == dma_pkg::CNT_ZERO)
               begin
                  s_d.evt[s_q.cur]     = 1'b1;
                  s_d.pending[s_q.cur] = 1'b0;
                  if (s_q.kind[s_q.cur][0])
                  begin
                     s_d.src[s_q.cur] = s_q.src_init[s_q.cur];
                     s_d.dst[s_q.cur] = s_q.dst_init[s_q.cur];
                     s_d.cnt[s_q.cur] = s_q.cnt_init[s_q.cur];
                  end
                  else
                  begin
                     s_d.chan_on[s_q.cur] = 1'b0;
                     set_v[dma_pkg::ST_DONE_LSB + 32'(s_q.cur)] = 1'b1;
                  end
               end
            end
         end
         default: s_d.state = dma_pkg::ENG_IDLE;
      endcase

      // Triggers: pins or any channel's completion, the channel's own included, chosen per channel.
      for (int i = 0; i < 4; i++)
      begin
         if (s_q.trig_sel[i][4])
            fire[i] = s_q.evt[s_q.trig_sel[i][1:0]];
         else
            fire[i] = t_edge[s_q.trig_sel[i][3:0]];
         if (!allow[i])
            s_d.pending[i] = 1'b0;
         else if (fire[i] && s_q.pending[i])
            set_v[dma_pkg::ST_OVRUN_LSB + i] = 1'b1;
         else if (fire[i])
            s_d.pending[i] = 1'b1;
      end
      // Hardware set wins over a same-cycle software clear.
      s_d.status = s_d.status | set_v;
   end

   always_ff @(posedge clk_sys or posedge reset)
   begin
      if (reset)
      begin
         s_q          <= '0;
         s_q.cnt      <= {4{dma_pkg::CNT_RESET}};
         s_q.cnt_init <= {4{dma_pkg::CNT_RESET}};
      end
      else
         s_q <= s_d;
   end

   assign prdata     = s_q.prdata;
   assign pslverr    = s_q.pslverr;
   assign pready     = 1'b1;
   assign mem_req    = (s_q.state != dma_pkg::ENG_IDLE) && allow[s_q.cur] &&
                       !outside(s_q.addr, s_q);
   assign mem_we     = s_q.we;
   assign mem_byte   = s_q.byte_size[s_q.cur];
   assign mem_addr   = s_q.addr;
   assign mem_wdata  = s_q.wdata;
   assign chan_event = s_q.evt;
   assign irq        = |(s_q.status & s_q.mask);
endmodule : dma_channels

/* dma_channels_chk.sv */
// Port checker of the DMA channel controller.
`timescale 1ns/1ps
module dma_channels_chk (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        idle_mode,
   input wire logic        sleep_mode,
   input wire logic        mem_req,
   input wire logic        mem_we,
   input wire logic        mem_byte,
   input wire logic        mem_ack,
   input wire logic [15:0] mem_addr,
   input wire logic [15:0] mem_wdata,
   input wire logic [15:0] mem_rdata,
   input wire logic [3:0]  chan_event
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (reset);
   sequence s_awake;
      (!idle_mode && !sleep_mode) [*3];
   endsequence
   property p_idle_stop;
      idle_mode [*4] |=> !mem_req;
   endproperty
   a_idle_stop: assert property (p_idle_stop) else $error("request in idle");
   property p_sleep_stop;
      sleep_mode [*4] |=> !mem_req;
   endproperty
   a_sleep_stop: assert property (p_sleep_stop) else $error("request in sleep");
   property p_read_write;
      s_awake ##0 (mem_req && mem_ack && !mem_we) |=> mem_req && mem_we;
   endproperty
   a_read_write: assert property (p_read_write) else $error("no write after read");
   property p_hold;
      s_awake ##0 (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr) && $stable(mem_we);
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   property p_copy;
      mem_req && mem_ack && !mem_we |=> mem_wdata ==
         ($past(mem_byte) ? {8'h00, $past(mem_rdata[7:0])} : $past(mem_rdata));
   endproperty
   a_copy: assert property (p_copy) else $error("write data differs");
   property p_gap;
      mem_req && mem_ack && mem_we |=> !mem_req;
   endproperty
   a_gap: assert property (p_gap) else $error("no gap after element");
   property p_read_first;
      $rose(mem_req) |-> !mem_we;
   endproperty
   a_read_first: assert property (p_read_first) else $error("write first");
   property p_ev_pulse;
      |chan_event |=> chan_event == 4'h0;
   endproperty
   a_ev_pulse: assert property (p_ev_pulse) else $error("event too long");
   property p_ev_cause;
      |chan_event |-> $past(mem_ack && mem_we, 1) || $past(mem_ack && mem_we, 2);
   endproperty
   a_ev_cause: assert property (p_ev_cause) else $error("event without write");
   c_event: cover property (|chan_event);
   c_sleep: cover property (sleep_mode && mem_req);
   c_write: cover property (mem_req && mem_ack && mem_we);
endmodule : dma_channels_chk
bind dma_channels dma_channels_chk chk (.clk_sys(clk_sys), .reset(reset),
   .idle_mode(idle_mode), .sleep_mode(sleep_mode), .mem_req(mem_req), .mem_we(mem_we),
   .mem_ack(mem_ack), .mem_byte(mem_byte), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
   .mem_rdata(mem_rdata), .chan_event(chan_event));

/* mem_model.sv */
// Data memory model answering the engine's memory port.
`timescale 1ns/1ps
module mem_model (
   input  wire logic        clk_sys,
   input  wire logic        slow,
   input  wire logic        mem_req,
   input  wire logic        mem_we,
   input  wire logic [15:0] mem_addr,
   input  wire logic [15:0] mem_wdata,
   output logic      [15:0] mem_rdata,
   output logic             mem_ack
);
   logic [15:0] ram [0:127];
   logic [15:0] last_q = 16'h0000;
   logic [1:0]  wait_q = 2'h0;
   initial
   begin
      for (int i = 0; i < 128; i++)
         ram[i] = 16'hA000 + 16'(i);
   end
   // Each access completes at once or after two wait cycles.
   assign mem_ack   = mem_req && (!slow || wait_q == 2'h2);
   // Outside an answered read the data lines show the inverse of the last value.
   assign mem_rdata = (mem_ack && !mem_we) ? ram[mem_addr[7:1]] : ~last_q;
   always @(posedge clk_sys)
   begin
      wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
      if (mem_ack && mem_we)
         ram[mem_addr[7:1]] <= mem_wdata;
      if (mem_ack && !mem_we)
         last_q <= ram[mem_addr[7:1]];
   end
endmodule : mem_model

/* dma_channels_tb.sv */
// Self-checking bench of the DMA channel controller.
`timescale 1ns/1ps
module dma_channels_tb;
   logic        clk_sys = 1'b0;
   logic        reset = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] trig_in = 16'h0000;
   logic        idle_mode = 1'b0;
   logic        sleep_mode = 1'b0;
   logic        slow = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, mem_req, mem_we, mem_byte, mem_ack, irq;
   logic [15:0] mem_addr, mem_wdata, mem_rdata;
   logic [3:0]  chan_event;
   int          fail_count = 0;
   int          check_count = 0;
   int          wr_acks = 0;
   int          ev0 = 0;
   dma_channels DUT (.clk_sys(clk_sys), .reset(reset), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .trig_in(trig_in), .idle_mode(idle_mode), .sleep_mode(sleep_mode),
      .mem_req(mem_req), .mem_we(mem_we), .mem_byte(mem_byte), .mem_addr(mem_addr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .chan_event(chan_event), .irq(irq));
   mem_model mem (.clk_sys(clk_sys), .slow(slow), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys)
   begin
      if (mem_req && mem_ack && mem_we)
         wr_acks <= wr_acks + 1;
      if (chan_event[0] === 1'b1)
         ev0 <= ev0 + 1;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic        e;
      apb(1'b1, a, d, q, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] q;
      logic        e;
      apb(1'b0, a, 32'h0, q, e);
      chk(q, x);
   endtask : rd
   task automatic setup_ch(input logic [7:0] b, input logic [15:0] s, d, c, k);
      wr(b, 32'h0);
      wr(b + 8'h04, 32'(s));
      wr(b + 8'h08, 32'(d));
      wr(b + 8'h0C, 32'(c));
      wr(b, 32'(k & 16'hFFFE));
      wr(b, 32'(k));
   endtask : setup_ch
   task automatic fire(input int p, input int n);
      int base;
      base = wr_acks;
      trig_in[p] <= 1'b1;
      repeat (4) @(posedge clk_sys);
      trig_in[p] <= 1'b0;
      repeat (60) @(posedge clk_sys);
      chk(wr_acks - base, n);
   endtask : fire
   task automatic t_reset();
      logic [31:0] q;
      logic        e;
      for (int n = 0; n < 4; n++)
         rd(8'h4C + 8'(16 * n), 32'h1);
      rd(8'h00, 32'h0);
      apb(1'b0, 8'h3C, 32'h0, q, e);
      chk({31'h0, e}, 32'h1);
      wr(8'h00, 32'h8000);
      wr(8'h04, 32'h00FE);
      wr(8'h08, 32'h0000);
   endtask : t_reset
   task automatic t_repeat();
      slow <= 1'b1;
      setup_ch(8'h40, 16'h0010, 16'h0020, 16'h0002, 16'h0545);
      fire(0, 0);
      for (int i = 0; i < 3; i++)
         fire(5, 1);
      chk(32'(mem.ram[16]), 32'hA008);
      chk(32'(mem.ram[17]), 32'hA008);
      chk(32'(mem.ram[18]), 32'hA012);
      chk(ev0, 1);
      rd(8'h48, 32'h0022);
      rd(8'h4C, 32'h0001);
      rd(8'h0C, 32'h0);
      slow <= 1'b0;
   endtask : t_repeat
   task automatic t_chain();
      setup_ch(8'h50, 16'h0030, 16'h0040, 16'h0001, 16'h0101);
      setup_ch(8'h60, 16'h0040, 16'h0050, 16'h0001, 16'h1101);
      fire(1, 2);
      chk(32'(mem.ram[40]), 32'hA018);
      rd(8'h0C, 32'h0006);
      chk({31'h0, irq}, 32'h0);
      wr(8'h10, 32'h000F);
      chk({31'h0, irq}, 32'h1);
      wr(8'h0C, 32'h0006);
      chk({31'h0, irq}, 32'h0);
      rd(8'h0C, 32'h0);
      fire(1, 0);
      rd(8'h50, 32'h0100);
      sleep_mode <= 1'b1;
      repeat (4) @(posedge clk_sys);
      sleep_mode <= 1'b0;
      repeat (4) @(posedge clk_sys);
      rd(8'h60, 32'h1100);
   endtask : t_chain
   task automatic t_modes();
      setup_ch(8'h50, 16'h000C, 16'h0063, 16'h0002, 16'h01BF);
      fire(1, 2);
      chk(32'(mem.ram[49]), 32'h0006);
      chk(32'(mem.ram[48]), 32'hA030);
      rd(8'h58, 32'h0063);
      rd(8'h5C, 32'h0002);
      rd(8'h0C, 32'h0);
      setup_ch(8'h50, 16'h0100, 16'h0040, 16'h0001, 16'h0101);
      fire(1, 0);
      rd(8'h0C, 32'h0200);
      rd(8'h50, 32'h0100);
      wr(8'h0C, 32'h0200);
   endtask : t_modes
   task automatic t_gate();
      wr(8'h14, 32'h1);
      rd(8'h40, 32'h0);
      wr(8'h4C, 32'h0007);
      fire(5, 0);
      wr(8'h14, 32'h0);
      rd(8'h40, 32'h0545);
      rd(8'h4C, 32'h0001);
   endtask : t_gate
   task automatic t_sleep();
      int base;
      int k;
      slow <= 1'b1;
      setup_ch(8'h70, 16'h0060, 16'h0070, 16'h0004, 16'h0359);
      base = wr_acks;
      trig_in[3] <= 1'b1;
      for (int n = 0; n < 60 && wr_acks == base; n++)
         @(posedge clk_sys);
      sleep_mode <= 1'b1;
      repeat (8) @(posedge clk_sys);
      sleep_mode <= 1'b0;
      trig_in[3] <= 1'b0;
      k = wr_acks - base;
      repeat (60) @(posedge clk_sys);
      chk(wr_acks - base, k);
      chk(32'(k > 0 && k < 4), 32'h1);
      rd(8'h7C, 32'(4 - k));
      rd(8'h70, 32'h0359);
      idle_mode <= 1'b1;
      repeat (4) @(posedge clk_sys);
      fire(3, 0);
      idle_mode <= 1'b0;
      slow <= 1'b0;
   endtask : t_sleep
   task automatic results();
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : results
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      fail_count++;
      results();
   end
   initial
   begin
      repeat (5) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      t_reset();
      t_repeat();
      t_chain();
      t_modes();
      t_gate();
      t_sleep();
      results();
   end
endmodule : dma_channels_tb
